// file: logic/fpm_monitor.sv
`timescale 1ns/100ps
module fpm_monitor #(
    parameter int PHASES = 6,
    parameter int ADC_W = 12,
    parameter int SAMPLE_CYCLES = fpm_pkg::SAMPLE_CYCLES,
    parameter int HICCUP_CYCLES = fpm_pkg::HICCUP_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic clock_enable,
    // Register port
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Analog front end, millivolt codes from converters
    input wire logic [ADC_W-1:0] current_monitor_pin,
    input wire logic [ADC_W-1:0] overvoltage_sense_pin,
    input wire logic [ADC_W-1:0] dac_reference_mv,
    input wire logic [ADC_W-1:0] ov_static_base_mv,
    input wire logic [ADC_W-1:0] ov_track_step_mv,
    input wire logic [ADC_W-1:0] ov_warn_margin_mv,
    input wire logic sense_open,
    input wire logic [PHASES-1:0] phase_over_limit,
    input wire logic average_over_reference,
    // Control inputs
    input wire logic power_enable_input,
    input wire logic thermal_enable_input,
    input wire logic zero_vid_code,
    input wire logic soft_start_done,
    input wire logic undervoltage_protection,
    input wire logic overtemp_fault,
    input wire logic cycle_start,
    // PWM from modulator and to drivers
    input wire logic [PHASES-1:0] pwm_request,
    output logic [PHASES-1:0] pwm_out,
    output logic [PHASES-1:0] pwm_oe,
    output logic [5:0] phase_limit_ref_code,
    output logic [2:0] average_ref_code,
    // Status
    output logic soft_start_request,
    output logic regulator_ready_out,
    output logic regulator_ready_oe,
    output logic vid_bus_alert_n_out,
    output logic vid_bus_alert_n_oe,
    output logic management_alert_n_out,
    output logic management_alert_n_oe
);
    initial begin
        if (PHASES < 1 || PHASES > 16 || ADC_W < 12 || SAMPLE_CYCLES < 2 || HICCUP_CYCLES < 2)
            $error("fpm_monitor: unsupported parameters");
    end

    typedef enum logic [1:0] {FPM_OFF, FPM_START, FPM_RUN, FPM_HICCUP} fpm_state_e;

    function automatic logic [7:0] fpm_sat_add(input logic [8:0] a, input logic [7:0] b);
        logic [9:0] s;
        s = {1'b0, a} + {{2{b[7]}}, b};
        if (s[9])
            fpm_sat_add = 8'h00;
        else if (s[8])
            fpm_sat_add = 8'hff;
        else
            fpm_sat_add = s[7:0];
    endfunction : fpm_sat_add

    // Two-flop synchronisers on pin-level inputs
    logic [1:0] pen_sync;
    logic [1:0] ten_sync;
    logic [1:0] open_sync;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pen_sync <= 2'b00;
            ten_sync <= 2'b00;
            open_sync <= 2'b00;
        end else if (clock_enable) begin
            pen_sync <= {pen_sync[0], power_enable_input};
            ten_sync <= {ten_sync[0], thermal_enable_input};
            open_sync <= {open_sync[0], sense_open};
        end
    end
    wire enabled = pen_sync[1] & ten_sync[1];

    // Configuration registers
    logic [7:0] ov_cfg, warn_dis, offset_cal, offset_add, max_current_limit_prog;
    logic [7:0] avg_cfg, lim_lo, lim_hi, multi_vr;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ov_cfg <= fpm_pkg::RST_CFG;
            warn_dis <= fpm_pkg::RST_CFG;
            offset_cal <= fpm_pkg::RST_CFG;
            offset_add <= fpm_pkg::RST_CFG;
            max_current_limit_prog <= fpm_pkg::RST_CFG;
            avg_cfg <= fpm_pkg::RST_CFG;
            lim_lo <= fpm_pkg::RST_CFG;
            lim_hi <= fpm_pkg::RST_CFG;
            multi_vr <= fpm_pkg::RST_MULTI_VR;
        end else if (clock_enable && reg_write) begin
            case (reg_addr)
                fpm_pkg::ADDR_OV_CFG: ov_cfg <= reg_wdata;
                fpm_pkg::ADDR_WARN_DIS: warn_dis <= reg_wdata;
                fpm_pkg::ADDR_OFFSET_CAL: offset_cal <= reg_wdata;
                fpm_pkg::ADDR_OFFSET_ADD: offset_add <= reg_wdata;
                fpm_pkg::ADDR_MAX_CURRENT_LIMIT_PROG: max_current_limit_prog <= reg_wdata;
                fpm_pkg::ADDR_AVG_OC_CFG: avg_cfg <= reg_wdata;
                fpm_pkg::ADDR_PH_LIM_LO: lim_lo <= reg_wdata;
                fpm_pkg::ADDR_PH_LIM_HI: lim_hi <= reg_wdata;
                fpm_pkg::ADDR_MULTI_VR: multi_vr <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Reference codes to the analog comparators
    assign phase_limit_ref_code = {lim_hi[fpm_pkg::PH_LIM_HI_LSB +: 3], lim_lo[2:0]};
    assign average_ref_code = avg_cfg[2:0];

    // Monitor thresholds
    localparam logic [ADC_W-1:0] ALERT_CODE = ADC_W'(fpm_pkg::ALERT_MV);
    localparam logic [ADC_W-1:0] SHUT_CODE = ADC_W'(fpm_pkg::SHUTDOWN_MV);
    localparam logic [ADC_W-1:0] REL_CODE = ADC_W'(fpm_pkg::OV_RELEASE_MV);
    wire mon_alert = current_monitor_pin >= ALERT_CODE;
    wire mon_shut = current_monitor_pin > SHUT_CODE;

    // Sampler: 2.5 V and above reads ffh before offsets, so a negative offset pulls it below
    logic [$clog2(SAMPLE_CYCLES)-1:0] sample_cnt;
    logic [7:0] iout_reading;
    wire [ADC_W+7:0] scaled = {current_monitor_pin, 8'h00} / ALERT_CODE;
    wire [8:0] raw_code = mon_alert ? 9'h0ff : scaled[8:0];
    wire [7:0] with_cal = fpm_sat_add(raw_code, offset_cal);
    wire [7:0] next_reading = fpm_sat_add({1'b0, with_cal}, offset_add);
    wire sample_tick = sample_cnt == ($clog2(SAMPLE_CYCLES))'(SAMPLE_CYCLES - 1);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sample_cnt <= '0;
            iout_reading <= 8'h00;
        end else if (clock_enable) begin
            sample_cnt <= sample_tick ? '0 : sample_cnt + 1'b1;
            if (sample_tick)
                iout_reading <= next_reading;
        end
    end

    // Overvoltage thresholds
    logic ov_latched;
    logic ov_crowbar;
    fpm_state_e state;
    wire [ADC_W-1:0] static_thr = ov_static_base_mv +
        (ov_track_step_mv * ADC_W'(ov_cfg[fpm_pkg::OV_STATIC_LSB +: 2]));
    wire [ADC_W-1:0] track_thr = dac_reference_mv +
        (ov_track_step_mv * ADC_W'(ov_cfg[fpm_pkg::OV_TRACK_LSB +: 3]));
    wire tracking = state == FPM_RUN && soft_start_done;
    wire [ADC_W-1:0] ov_thr = tracking ? track_thr : static_thr;
    wire ov_now = (overvoltage_sense_pin > ov_thr) || open_sync[1];
    wire ov_below_release = overvoltage_sense_pin < (dac_reference_mv + REL_CODE);
    wire ov_warn = overvoltage_sense_pin > (ov_thr - ov_warn_margin_mv) &&
        !warn_dis[fpm_pkg::WARN_OV_DIS_BIT];
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ov_latched <= 1'b0;
            ov_crowbar <= 1'b0;
        end else if (clock_enable) begin
            if (ov_now)
                ov_latched <= 1'b1;
            if (ov_now)
                ov_crowbar <= 1'b1;
            else if (ov_below_release)
                ov_crowbar <= 1'b0;
        end
    end
    wire ov_active = ov_latched || ov_now;

    // Supervisor and hiccup timer
    logic [$clog2(HICCUP_CYCLES)-1:0] hiccup_cnt;
    logic first_start_done;
    wire oc_trip = mon_shut || average_over_reference;
    wire off_code = zero_vid_code && !(multi_vr == fpm_pkg::MULTI_VR_KEEP && first_start_done);
    wire hiccup_end = hiccup_cnt == ($clog2(HICCUP_CYCLES))'(HICCUP_CYCLES - 1);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= FPM_OFF;
            hiccup_cnt <= '0;
            first_start_done <= 1'b0;
        end else if (clock_enable) begin
            case (state)
                FPM_OFF: begin
                    if (enabled && !ov_active && !zero_vid_code)
                        state <= FPM_START;
                end
                FPM_START: begin
                    if (!enabled || ov_active || off_code)
                        state <= FPM_OFF;
                    else if (oc_trip)
                        state <= FPM_HICCUP;
                    else if (soft_start_done)
                        state <= FPM_RUN;
                end
                FPM_RUN: begin
                    first_start_done <= 1'b1;
                    if (!enabled || ov_active || off_code)
                        state <= FPM_OFF;
                    else if (oc_trip)
                        state <= FPM_HICCUP;
                end
                FPM_HICCUP: begin
                    hiccup_cnt <= hiccup_cnt + 1'b1;
                    if (ov_active) begin
                        state <= FPM_OFF;
                        hiccup_cnt <= '0;
                    end else if (hiccup_end) begin
                        hiccup_cnt <= '0;
                        state <= enabled ? FPM_START : FPM_OFF;
                    end
                end
                default: state <= FPM_OFF;
            endcase
        end
    end
    assign soft_start_request = state == FPM_START;

    // Cycle-by-cycle phase limit; cleared at each new switching cycle
    logic [PHASES-1:0] phase_block;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            phase_block <= '0;
        else if (clock_enable) begin
            if (cycle_start)
                phase_block <= phase_over_limit;
            else
                phase_block <= phase_block | phase_over_limit;
        end
    end
    wire [PHASES-1:0] phase_gate = phase_block | phase_over_limit;

    // PWM drive: crowbar low, float, or regulate
    logic [PHASES-1:0] next_pwm, next_oe;
    always_comb begin
        next_pwm = '0;
        next_oe = '0;
        if (ov_active) begin
            next_oe = (ov_now || ov_crowbar) ? '1 : '0;
        end else if (state == FPM_START || state == FPM_RUN) begin
            next_pwm = pwm_request & ~phase_gate;
            next_oe = '1;
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pwm_out <= '0;
            pwm_oe <= '0;
        end else if (clock_enable) begin
            pwm_out <= next_pwm;
            pwm_oe <= next_oe;
        end
    end

    // Ready and alerts, open-drain: enable high pulls the line low
    wire ready_ok = state == FPM_RUN && !ov_active && !undervoltage_protection &&
        !overtemp_fault && !oc_trip;
    logic ready_q, vid_alert_q, mgmt_alert_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ready_q <= 1'b0;
            vid_alert_q <= 1'b0;
            mgmt_alert_q <= 1'b0;
        end else if (clock_enable) begin
            ready_q <= ready_ok;
            vid_alert_q <= mon_alert;
            mgmt_alert_q <= mon_alert || ov_warn;
        end
    end
    assign regulator_ready_out = 1'b0;
    assign regulator_ready_oe = !ready_q;
    assign vid_bus_alert_n_out = 1'b0;
    assign vid_bus_alert_n_oe = vid_alert_q;
    assign management_alert_n_out = 1'b0;
    assign management_alert_n_oe = mgmt_alert_q;

    // Read path
    wire [15:0] status_word = 16'(ov_warn) << fpm_pkg::STATUS_OV_WARN_BIT;
    logic [15:0] read_mux;
    always_comb begin
        case (reg_addr)
            fpm_pkg::ADDR_IOUT: read_mux = {8'h00, iout_reading};
            fpm_pkg::ADDR_IOUT_MGMT: read_mux = {8'h00, iout_reading};
            fpm_pkg::ADDR_MAX_CURRENT_LIMIT: read_mux = {8'h00, max_current_limit_prog};
            fpm_pkg::ADDR_STATUS_WORD: read_mux = status_word;
            fpm_pkg::ADDR_OV_CFG: read_mux = {8'h00, ov_cfg};
            fpm_pkg::ADDR_WARN_DIS: read_mux = {8'h00, warn_dis};
            fpm_pkg::ADDR_OFFSET_CAL: read_mux = {8'h00, offset_cal};
            fpm_pkg::ADDR_OFFSET_ADD: read_mux = {8'h00, offset_add};
            fpm_pkg::ADDR_MAX_CURRENT_LIMIT_PROG: read_mux = {8'h00, max_current_limit_prog};
            fpm_pkg::ADDR_AVG_OC_CFG: read_mux = {8'h00, avg_cfg};
            fpm_pkg::ADDR_PH_LIM_LO: read_mux = {8'h00, lim_lo};
            fpm_pkg::ADDR_PH_LIM_HI: read_mux = {8'h00, lim_hi};
            fpm_pkg::ADDR_MULTI_VR: read_mux = {8'h00, multi_vr};
            default: read_mux = 16'h0000;
        endcase
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else if (clock_enable) begin
            reg_rvalid <= reg_read;
            if (reg_read)
                reg_rdata <= read_mux;
        end
    end
endmodule : fpm_monitor

// file: shared/fpm_pkg.sv
package fpm_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_IOUT = 8'h15;
    localparam logic [7:0] ADDR_MAX_CURRENT_LIMIT = 8'h21;
    localparam logic [7:0] ADDR_STATUS_WORD = 8'h79;
    localparam logic [7:0] ADDR_IOUT_MGMT = 8'h8c;
    localparam logic [7:0] ADDR_OV_CFG = 8'hd8;
    localparam logic [7:0] ADDR_WARN_DIS = 8'hdf;
    localparam logic [7:0] ADDR_OFFSET_CAL = 8'he4;
    localparam logic [7:0] ADDR_OFFSET_ADD = 8'he5;
    localparam logic [7:0] ADDR_MAX_CURRENT_LIMIT_PROG = 8'hea;
    localparam logic [7:0] ADDR_AVG_OC_CFG = 8'hf2;
    localparam logic [7:0] ADDR_PH_LIM_LO = 8'hf3;
    localparam logic [7:0] ADDR_PH_LIM_HI = 8'hf4;
    localparam logic [7:0] ADDR_MULTI_VR = 8'he0;
    // Field positions
    localparam int OV_STATIC_LSB = 3;
    localparam int OV_TRACK_LSB = 0;
    localparam int WARN_OV_DIS_BIT = 7;
    localparam int STATUS_OV_WARN_BIT = 15;
    localparam int PH_LIM_HI_LSB = 3;
    // Reset values and register codes
    localparam logic [7:0] RST_MULTI_VR = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] MULTI_VR_KEEP = 8'h01;
    localparam logic [7:0] FULL_SCALE = 8'hff;
    // Analog thresholds in millivolts on the monitor code scale
    localparam int ALERT_MV = 2500;
    localparam int SHUTDOWN_MV = 3000;
    localparam int OV_RELEASE_MV = 100;
    // Timing
    localparam int CLOCK_HZ = 20_000_000;
    localparam int SAMPLE_US = 88;
    localparam int HICCUP_MS = 9;
    localparam int SAMPLE_CYCLES = SAMPLE_US * (CLOCK_HZ / 1_000_000);
    localparam int HICCUP_CYCLES = HICCUP_MS * (CLOCK_HZ / 1000);
endpackage : fpm_pkg

// file: testbench/fpm_checker.sv
`timescale 1ns/100ps
module fpm_checker #(
    parameter int PHASES = 6,
    parameter int ADC_W = 12,
    parameter int SAMPLE_CYCLES = 16,
    parameter int HICCUP_CYCLES = 64
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Inputs watched
    input wire logic reg_read,
    input wire logic [ADC_W-1:0] current_monitor_pin,
    input wire logic sense_open,
    input wire logic [PHASES-1:0] phase_over_limit,
    input wire logic average_over_reference,
    input wire logic power_enable_input,
    input wire logic thermal_enable_input,
    input wire logic cycle_start,
    // Outputs watched
    input wire logic reg_rvalid,
    input wire logic [PHASES-1:0] pwm_out,
    input wire logic [PHASES-1:0] pwm_oe,
    input wire logic soft_start_request,
    input wire logic regulator_ready_oe,
    input wire logic vid_bus_alert_n_oe,
    input wire logic management_alert_n_oe
);
    localparam int HLO = HICCUP_CYCLES - 6;
    localparam int HHI = HICCUP_CYCLES;
    int hi_cnt;
    logic [4:0] open_sr;
    logic ov_seen;
    // Open sense must persist past the input synchroniser before we call it latched
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hi_cnt <= 0;
            open_sr <= '0;
            ov_seen <= 1'b0;
        end else begin
            hi_cnt <= (current_monitor_pin >= 2500) ? hi_cnt + 1 : 0;
            open_sr <= {open_sr[3:0], sense_open};
            ov_seen <= ov_seen | (&open_sr);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    property p_rd; reg_read |=> reg_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read answer missing");
    property p_alert; hi_cnt > SAMPLE_CYCLES + 3 |-> vid_bus_alert_n_oe && management_alert_n_oe; endproperty
    a_alert: assert property (p_alert) else $error("alerts not low at full scale");
    property p_oc; soft_start_request && current_monitor_pin > 3000 && !sense_open |-> ##[1:3] pwm_oe == '0; endproperty
    a_oc: assert property (p_oc) else $error("monitor trip did not float pwm");
    property p_hic; soft_start_request && current_monitor_pin > 3000 && power_enable_input && thermal_enable_input |-> ##3 !soft_start_request ##[HLO:HHI] soft_start_request; endproperty
    a_hic: assert property (p_hic) else $error("hiccup wait wrong");
    property p_avg; !regulator_ready_oe && average_over_reference && !sense_open |-> ##[1:3] (pwm_oe == '0 && regulator_ready_oe); endproperty
    a_avg: assert property (p_avg) else $error("average trip did not shut down");
    property p_ph; (phase_over_limit[0] && !cycle_start) ##1 (!cycle_start)[*3] |-> !pwm_out[0]; endproperty
    a_ph: assert property (p_ph) else $error("limited phase still high");
    property p_ov; sense_open[*6] |-> pwm_oe == '1 && pwm_out == '0; endproperty
    a_ov: assert property (p_ov) else $error("open sense without crowbar");
    property p_ovl; ov_seen |=> regulator_ready_oe; endproperty
    a_ovl: assert property (p_ovl) else $error("ready released after overvoltage");
    property p_dis; (!power_enable_input)[*6] |-> regulator_ready_oe; endproperty
    a_dis: assert property (p_dis) else $error("ready high while disabled");
endmodule : fpm_checker
bind fpm_monitor fpm_checker #(.PHASES(PHASES), .ADC_W(ADC_W), .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .HICCUP_CYCLES(HICCUP_CYCLES)) u_fpm_checker (.clock(clock), .resetn(resetn),
    .reg_read(reg_read), .current_monitor_pin(current_monitor_pin), .sense_open(sense_open),
    .phase_over_limit(phase_over_limit), .average_over_reference(average_over_reference),
    .power_enable_input(power_enable_input), .thermal_enable_input(thermal_enable_input),
    .cycle_start(cycle_start), .reg_rvalid(reg_rvalid), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .soft_start_request(soft_start_request), .regulator_ready_oe(regulator_ready_oe),
    .vid_bus_alert_n_oe(vid_bus_alert_n_oe), .management_alert_n_oe(management_alert_n_oe));

// file: testbench/fpm_host.sv
`timescale 1ns/100ps
module fpm_host (
    // Clock
    input wire logic clock,
    // Register port
    output logic reg_write,
    output logic reg_read,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    // Open-drain lines
    input wire logic regulator_ready_oe,
    input wire logic vid_bus_alert_n_oe,
    input wire logic management_alert_n_oe,
    output logic ready_line,
    output logic vid_alert_n,
    output logic mgmt_alert_n
);
    // Pull-ups hold each line high unless the device sinks it
    assign ready_line = !regulator_ready_oe;
    assign vid_alert_n = !vid_bus_alert_n_oe;
    assign mgmt_alert_n = !management_alert_n_oe;
    initial begin
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #2;
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock);
        #2;
        reg_write = 1'b0;
        // Idle data is scrambled so a stale byte is never mistaken for a write
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        #2;
        reg_read = 1'b1;
        reg_addr = a;
        @(posedge clock);
        #2;
        reg_read = 1'b0;
        reg_addr = ~a;
    endtask : rd
endmodule : fpm_host

// file: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam int SC = 16;
    localparam int HC = 64;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic reg_write, reg_read, reg_rvalid, ssr, rdy_oe, va_oe, ma_oe, rdy, vid_alert_n, mgmt_alert_n;
    logic [7:0] reg_addr, reg_wdata;
    logic [15:0] reg_rdata;
    logic [11:0] mon = '0, ovs = 12'd500;
    logic sopen = 0, avg = 0, pen = 1, ten = 1, zvid = 0, ssd = 0, uv = 0, ot = 0, cs = 0;
    logic [5:0] pol = '0, preq = '0, pwm_out, pwm_oe, plr;
    logic [2:0] arc;
    logic [31:0] ent;
    logic [31:0] expq[$];
    logic [7:0] rw[9] = '{8'hd8, 8'hdf, 8'he4, 8'he5, 8'hea, 8'hf2, 8'hf3, 8'hf4, fpm_pkg::ADDR_MULTI_VR};
    logic [7:0] v[9];
    logic [11:0] tm[8] = '{12'd0, 12'd1250, 12'd2490, 12'd2500, 12'd2600, 12'd2600, 12'd1250, 12'd0};
    logic [7:0] t4[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hfc, 8'hfe, 8'h05, 8'hfc};
    logic [7:0] t5[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hfe, 8'h03, 8'h00};
    int miscompares = 0;
    int checks = 0;
    fpm_monitor #(.SAMPLE_CYCLES(SC), .HICCUP_CYCLES(HC)) u_fpm_monitor (
        .clock(clock), .resetn(resetn), .clock_enable(1'b1),
        .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .current_monitor_pin(mon), .overvoltage_sense_pin(ovs), .dac_reference_mv(12'd1000),
        .ov_static_base_mv(12'd2000), .ov_track_step_mv(12'd100), .ov_warn_margin_mv(12'd200),
        .sense_open(sopen), .phase_over_limit(pol), .average_over_reference(avg),
        .power_enable_input(pen), .thermal_enable_input(ten), .zero_vid_code(zvid),
        .soft_start_done(ssd), .undervoltage_protection(uv), .overtemp_fault(ot),
        .cycle_start(cs), .pwm_request(preq), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .phase_limit_ref_code(plr), .average_ref_code(arc), .soft_start_request(ssr),
        .regulator_ready_out(), .regulator_ready_oe(rdy_oe), .vid_bus_alert_n_out(),
        .vid_bus_alert_n_oe(va_oe), .management_alert_n_out(), .management_alert_n_oe(ma_oe));
    fpm_host u_fpm_host (.clock(clock), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .regulator_ready_oe(rdy_oe),
        .vid_bus_alert_n_oe(va_oe), .management_alert_n_oe(ma_oe), .ready_line(rdy),
        .vid_alert_n(vid_alert_n), .mgmt_alert_n(mgmt_alert_n));
    initial begin
        forever #25 clock = ~clock;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : cyc
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
        expq.push_back({m, e});
        u_fpm_host.rd(a);
    endtask : rd
    task automatic do_reset;
        resetn = 1'b0;
        cyc(10);
        resetn = 1'b1;
    endtask : do_reset
    task automatic wait_rdy(input logic want);
        int n;
        n = 0;
        while (rdy !== want && n < 400) begin
            cyc(1);
            n++;
        end
        chk("ready line", rdy, want);
    endtask : wait_rdy
    task automatic wt_ssr(input logic want, output int n);
        n = 0;
        while (ssr !== want && n < 400) begin
            cyc(1);
            n++;
        end
        chk("soft start request", ssr, want);
    endtask : wt_ssr
    function automatic logic [7:0] scale(input logic [11:0] m, input logic [7:0] a, input logic [7:0] b);
        int r;
        // Full scale pins at ffh so a negative offset lands exactly that far below it
        r = (m >= 12'd2500) ? 255 : int'(m) * 256 / 2500;
        r = r + int'($signed(a)) + int'($signed(b));
        return (r > 255) ? 8'hff : (r < 0) ? 8'h00 : r[7:0];
    endfunction : scale
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    always @(posedge clock) begin
        if (reg_rvalid === 1'b1) begin
            ent = (expq.size() > 0) ? expq.pop_front() : 32'hffff_dead;
            chk("reg_rdata", reg_rdata & ent[31:16], ent[15:0]);
        end
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        close_out();
    end
    initial begin
        int n;
        void'($urandom(31));
        tm[7] = 12'($urandom_range(2499));
        do_reset();
        foreach (rw[i]) rd(rw[i], 16'h0000);
        foreach (rw[i]) begin
            v[i] = 8'($urandom);
            u_fpm_host.wr(rw[i], v[i]);
            rd(rw[i], {8'h00, v[i]});
        end
        chk("avg ref code", arc, v[5][2:0]);
        chk("phase ref code", plr, {v[7][5:3], v[6][2:0]});
        rd(8'h21, {8'h00, v[4]});
        rd(8'h00, 16'h0000);
        $display("registers done");
        for (int i = 0; i < 8; i++) begin
            mon = tm[i];
            u_fpm_host.wr(8'he4, t4[i]);
            u_fpm_host.wr(8'he5, t5[i]);
            u_fpm_host.wr(8'h15, 8'h5a);
            cyc(2 * SC + 4);
            rd(8'h15, {8'h00, scale(tm[i], t4[i], t5[i])});
            if (tm[i] >= 12'd2500) chk("alerts", {vid_alert_n, mgmt_alert_n}, 2'b00);
        end
        foreach (rw[i]) u_fpm_host.wr(rw[i], 8'h00);
        $display("current reading done");
        chk("ready in start", rdy, 1'b0);
        ssd = 1;
        wait_rdy(1);
        preq = 6'($urandom) | 6'h01;
        cs = 1;
        cyc(1);
        cs = 0;
        cyc(3);
        chk("pwm run", {pwm_oe, pwm_out}, {6'h3f, preq});
        pol = 6'h01;
        cyc(1);
        pol = '0;
        cyc(3);
        chk("pwm limited", pwm_out, preq & 6'h3e);
        chk("ready kept", rdy, 1'b1);
        cs = 1;
        cyc(1);
        cs = 0;
        cyc(3);
        chk("pwm resumed", pwm_out, preq);
        for (int k = 0; k < 5; k++) begin
            {uv, ot, pen, ten, zvid} = 5'b00110 ^ (5'b10000 >> k);
            cyc(6);
            chk("ready on fault", rdy, 1'b0);
            {uv, ot, pen, ten, zvid} = 5'b00110;
            wait_rdy(1);
        end
        u_fpm_host.wr(fpm_pkg::ADDR_MULTI_VR, 8'h01);
        zvid = 1;
        cyc(6);
        chk("ready on zero code", rdy, 1'b1);
        zvid = 0;
        u_fpm_host.wr(fpm_pkg::ADDR_MULTI_VR, 8'h00);
        $display("ready and phase limit done");
        avg = 1;
        cyc(1);
        avg = 0;
        cyc(3);
        chk("trip", {pwm_oe, rdy}, 7'h00);
        wt_ssr(1, n);
        chk("hiccup wait", n > HC - 8 && n < HC + 4, 1'b1);
        mon = 12'd3100;
        wt_ssr(0, n);
        wt_ssr(1, n);
        chk("retry wait", n > HC - 8 && n < HC + 4, 1'b1);
        wt_ssr(0, n);
        mon = 12'd0;
        wait_rdy(1);
        avg = 1;
        cyc(1);
        avg = 0;
        pen = 0;
        cyc(HC + 20);
        chk("no retry when off", ssr, 1'b0);
        pen = 1;
        wait_rdy(1);
        $display("overcurrent done");
        u_fpm_host.wr(8'hd8, 8'h0a);
        ovs = 12'd1100;
        cyc(4);
        rd(8'h79, 16'h8000, 16'h8000);
        chk("warning lines", {mgmt_alert_n, rdy}, 2'b01);
        u_fpm_host.wr(8'hdf, 8'h80);
        cyc(4);
        rd(8'h79, 16'h0000, 16'h8000);
        chk("warning masked", mgmt_alert_n, 1'b1);
        for (int k = 0; k < 2; k++) begin
            // After the latch the state leaves run, so the recurrence meets the static threshold
            ovs = (k == 0) ? 12'd1300 : 12'd2200;
            cyc(4);
            chk("crowbar", {pwm_oe, pwm_out, rdy}, 13'h1f80);
            ovs = 12'd500;
            cyc(4);
            chk("float", pwm_oe, 6'h00);
        end
        pen = 0;
        cyc(6);
        pen = 1;
        cyc(20);
        chk("latched", {pwm_oe, rdy}, 7'h00);
        do_reset();
        pen = 0;
        u_fpm_host.wr(8'hd8, 8'h0a);
        ovs = 12'd2050;
        cyc(6);
        chk("below static", pwm_oe, 6'h00);
        ovs = 12'd2150;
        cyc(4);
        chk("static trip", {pwm_oe, pwm_out}, 12'hfc0);
        ovs = 12'd500;
        pen = 1;
        do_reset();
        sopen = 1;
        cyc(8);
        chk("open sense", {pwm_oe, pwm_out, rdy}, 13'h1f80);
        $display("overvoltage done");
        cyc(2);
        chk("reads pending", expq.size(), 16'h0000);
        close_out();
    end
endmodule : tb_top
